// ---- inc/grip_defines.svh ----
// Purpose: Offsets, field codes, limits and scale figures of the axis
//          command bank.
// Assumes: Byte-addressed command space, 4-bit address.
// Notes:   Definitions only.
`ifndef GRIP_DEFINES_SVH
`define GRIP_DEFINES_SVH

`define ADDR_W              4
`define OFS_COMMON_SPEED    4'h4
`define OFS_COMMON_FORCE    4'h5
`define OFS_SECOND_TARGET   4'h6
`define OFS_SECOND_SPEED    4'h7
`define OFS_SECOND_FORCE    4'h8
`define OFS_THIRD_TARGET    4'h9
`define OFS_THIRD_SPEED     4'hA
`define OFS_THIRD_FORCE     4'hB
`define OFS_SPREAD_TARGET   4'hC
`define OFS_SPREAD_SPEED    4'hD
`define OFS_SPREAD_FORCE    4'hE
`define CMD_RESET_VAL       8'h00
`define UNMAPPED_READ       8'h00

`define MODE_BASIC          2'h0
`define MODE_PINCH          2'h1
`define MODE_WIDE           2'h2
`define MODE_SCISSOR        2'h3

`define SPREAD_POS_BASIC    8'h89
`define SPREAD_POS_PINCH    8'hDC
`define SPREAD_POS_WIDE     8'h1B
`define FINGER_POS_SCISSOR  8'h00

`define FINGER_SOFT_MIN     8'h06
`define FINGER_SOFT_MAX     8'hF8
`define SPREAD_SOFT_MIN     8'h00
`define SPREAD_SOFT_MAX     8'hFF
`define SPREAD_SOFT_MAX_ICS 8'hDC

`define SPEED_MIN_CMPS      16'h0898
`define SPEED_STEP_CMPS     16'h0022
`define FORCE_MIN_MN        16'h3A98
`define FORCE_STEP_MN       16'h00AF
`define CURRENT_BASE        8'h20
`define CURRENT_KNEE        8'h40

`define STEP_ACC_W          16
`define STEP_RATE_BASE      16'h0010
`define BLANK_STEPS         4'h8

`endif

// ---- inc/grip_pkg.sv ----
// Purpose: Shared types of the axis command bank.
// Assumes: Four axes: A, B, C and the spread axis.
// Notes:   Numeric constants live in grip_defines.svh.
package grip_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {AX_IDLE, AX_MOVING, AX_AT_TARGET, AX_CONTACT}
    axis_phase_e;
endpackage

// ---- rtl/axis_motion.sv ----
// Purpose: One axis: steps toward its target, stops on over-current.
// Assumes: Motor current sample is synchronous to sys_clk.
// Notes:   Speed only sets the step rate; it never starts a motion.
`timescale 1ns/10ps
`default_nettype none
`include "grip_defines.svh"
module axis_motion (
  input  wire logic            sys_clk,        // System clock
  input  wire logic            rst,            // Synchronous reset
  input  wire logic            go_request,     // Go to target level
  input  wire grip_pkg::byte_t target,         // Clamped target
  input  wire grip_pkg::byte_t speed_code,     // Selected speed byte
  input  wire grip_pkg::byte_t current_limit,  // Current ceiling
  input  wire grip_pkg::byte_t motor_current,  // Measured current
  output var  grip_pkg::byte_t position,       // Axis position
  output var grip_pkg::axis_phase_e phase      // Axis phase
);
  import grip_pkg::*;

  logic                   go_d_reg;
  byte_t                  target_d_reg;
  logic [`STEP_ACC_W-1:0] acc_reg;
  logic [`STEP_ACC_W:0]   acc_sum;
  logic [3:0]             blank_reg;
  logic                   start;
  logic                   step;
  logic                   blank_done;

  // A new target or a fresh go starts; a speed write cannot
  assign start      = go_request && (!go_d_reg || target != target_d_reg);
  assign acc_sum    = {1'b0, acc_reg} + {1'b0, `STEP_RATE_BASE}
                    + {9'h000, speed_code};
  assign step       = acc_sum[`STEP_ACC_W] && phase == AX_MOVING;
  assign blank_done = blank_reg == `BLANK_STEPS;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      go_d_reg     <= 1'b0;
      target_d_reg <= `CMD_RESET_VAL;
      acc_reg      <= '0;
    end else begin
      go_d_reg     <= go_request;
      target_d_reg <= target;
      acc_reg      <= acc_sum[`STEP_ACC_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase <= AX_IDLE;
    end else if (!go_request) begin
      phase <= AX_IDLE;
    end else if (start) begin
      phase <= (position == target) ? AX_AT_TARGET : AX_MOVING;
    end else if (phase == AX_MOVING) begin
      if (position == target) begin
        phase <= AX_AT_TARGET;
      end else if (blank_done && motor_current > current_limit) begin
        phase <= AX_CONTACT;
      end
    end
  end

  // Limit ignored over the first few steps of each motion
  always_ff @(posedge sys_clk) begin
    if (rst || start) begin
      blank_reg <= 4'h0;
    end else if (step && !blank_done) begin
      blank_reg <= blank_reg + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      position <= `CMD_RESET_VAL;
    end else if (step && position != target) begin
      position <= (target > position) ? position + 8'h01 : position - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/force_current_map.sv ----
// Purpose: Turns a force code into a motor current ceiling and a force.
// Assumes: Force code changes rarely; one cycle of latency is harmless.
// Notes:   Bent two-slope curve stands in for the non-linear motor law.
`timescale 1ns/10ps
`default_nettype none
`include "grip_defines.svh"
module force_current_map (
  input  wire logic           sys_clk,       // System clock
  input  wire logic           rst,           // Synchronous reset
  input  wire grip_pkg::byte_t force_code,   // Selected force byte
  output var  grip_pkg::byte_t current_limit, // Current ceiling
  output var  grip_pkg::word_t force_mn     // Force in millinewton
);
  import grip_pkg::*;

  word_t force_prod;
  byte_t limit_next;

  assign force_prod = 16'(force_code * `FORCE_STEP_MN);

  always_comb begin
    if (force_code[7]) begin
      limit_next = `CURRENT_BASE + `CURRENT_KNEE + {1'b0, force_code[6:0]};
    end else begin
      limit_next = `CURRENT_BASE + {2'b00, force_code[6:1]};
    end
  end

  // Code 0 gives the floor force, not zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      current_limit <= `CURRENT_BASE;
      force_mn      <= `FORCE_MIN_MN;
    end else begin
      current_limit <= limit_next;
      force_mn      <= `FORCE_MIN_MN + force_prod;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/gripper_axis_command_regs.sv ----
// Purpose: Per-axis command bytes of a three-finger gripper and the
//          selection that turns them into one command set per axis.
// Assumes: Controller writes bytes synchronously; flags are plain levels.
// Notes:   Axis order is A, B, C, spread. Read data lag one cycle.
`timescale 1ns/10ps
`default_nettype none
`include "grip_defines.svh"
module gripper_axis_command_regs (
  input  wire logic                 sys_clk,          // System clock
  input  wire logic                 rst,              // Sync reset, high
  input  wire logic                 wr_strobe,        // Byte write
  input  wire logic [`ADDR_W-1:0]   wr_addr,          // Write byte offset
  input  wire grip_pkg::byte_t      wr_data,          // Write byte
  input  wire logic [`ADDR_W-1:0]   rd_addr,          // Read byte offset
  output var  grip_pkg::byte_t      rd_data,          // Read byte
  input  wire grip_pkg::byte_t      common_target,    // Byte 3 target
  input  wire logic                 individual_finger_control, // Flag
  input  wire logic                 individual_spread_control, // Flag
  input  wire logic [1:0]           grasping_mode_select,      // Mode
  input  wire logic                 go_request,       // Go to target
  input  wire grip_pkg::byte_t [3:0] motor_current,   // Per axis current
  output wire grip_pkg::byte_t [3:0] axis_position,   // Per axis position
  output wire grip_pkg::byte_t [3:0] axis_target,     // Clamped targets
  output wire grip_pkg::word_t [3:0] axis_speed_cmps, // Speed, 0.01 mm/s
  output wire grip_pkg::word_t [3:0] axis_force_mn,   // Force, mN
  output wire logic [3:0]            axis_moving,     // Axis in motion
  output wire logic [3:0]            axis_at_target,  // Target reached
  output wire logic [3:0]            object_detect    // Stopped on contact
);
  import grip_pkg::*;

  byte_t common_speed_reg;
  byte_t common_force_reg;
  byte_t second_finger_target_reg;
  byte_t second_finger_speed_reg;
  byte_t second_finger_force_reg;
  byte_t third_finger_target_reg;
  byte_t third_finger_speed_reg;
  byte_t third_finger_force_reg;
  byte_t spread_axis_target_reg;
  byte_t spread_axis_speed_reg;
  byte_t spread_axis_force_reg;
  byte_t rd_data_next;

  logic  fingers_own;
  byte_t [3:0] sel_target;
  byte_t [3:0] sel_speed;
  byte_t [3:0] sel_force;
  byte_t [3:0] soft_min;
  byte_t [3:0] soft_max;
  byte_t spread_mode_target;

  // Every byte holds until rewritten; no flag change clears it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      common_speed_reg         <= `CMD_RESET_VAL;
      common_force_reg         <= `CMD_RESET_VAL;
      second_finger_target_reg <= `CMD_RESET_VAL;
      second_finger_speed_reg  <= `CMD_RESET_VAL;
      second_finger_force_reg  <= `CMD_RESET_VAL;
      third_finger_target_reg  <= `CMD_RESET_VAL;
      third_finger_speed_reg   <= `CMD_RESET_VAL;
      third_finger_force_reg   <= `CMD_RESET_VAL;
      spread_axis_target_reg   <= `CMD_RESET_VAL;
      spread_axis_speed_reg    <= `CMD_RESET_VAL;
      spread_axis_force_reg    <= `CMD_RESET_VAL;
    end else if (wr_strobe) begin
      unique case (wr_addr)
        `OFS_COMMON_SPEED:  common_speed_reg         <= wr_data;
        `OFS_COMMON_FORCE:  common_force_reg         <= wr_data;
        `OFS_SECOND_TARGET: second_finger_target_reg <= wr_data;
        `OFS_SECOND_SPEED:  second_finger_speed_reg  <= wr_data;
        `OFS_SECOND_FORCE:  second_finger_force_reg  <= wr_data;
        `OFS_THIRD_TARGET:  third_finger_target_reg  <= wr_data;
        `OFS_THIRD_SPEED:   third_finger_speed_reg   <= wr_data;
        `OFS_THIRD_FORCE:   third_finger_force_reg   <= wr_data;
        `OFS_SPREAD_TARGET: spread_axis_target_reg   <= wr_data;
        `OFS_SPREAD_SPEED:  spread_axis_speed_reg    <= wr_data;
        `OFS_SPREAD_FORCE:  spread_axis_force_reg    <= wr_data;
        // Unmapped offsets are dropped silently
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (rd_addr)
      `OFS_COMMON_SPEED:  rd_data_next = common_speed_reg;
      `OFS_COMMON_FORCE:  rd_data_next = common_force_reg;
      `OFS_SECOND_TARGET: rd_data_next = second_finger_target_reg;
      `OFS_SECOND_SPEED:  rd_data_next = second_finger_speed_reg;
      `OFS_SECOND_FORCE:  rd_data_next = second_finger_force_reg;
      `OFS_THIRD_TARGET:  rd_data_next = third_finger_target_reg;
      `OFS_THIRD_SPEED:   rd_data_next = third_finger_speed_reg;
      `OFS_THIRD_FORCE:   rd_data_next = third_finger_force_reg;
      `OFS_SPREAD_TARGET: rd_data_next = spread_axis_target_reg;
      `OFS_SPREAD_SPEED:  rd_data_next = spread_axis_speed_reg;
      `OFS_SPREAD_FORCE:  rd_data_next = spread_axis_force_reg;
      default:            rd_data_next = `UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data <= `UNMAPPED_READ;
    end else begin
      rd_data <= rd_data_next;
    end
  end

  // Scissor mode pins the fingers unless the spread axis is free
  assign fingers_own = individual_finger_control
                    && !(grasping_mode_select == `MODE_SCISSOR
                         && !individual_spread_control);

  always_comb begin
    unique case (grasping_mode_select)
      `MODE_BASIC:   spread_mode_target = `SPREAD_POS_BASIC;
      `MODE_PINCH:   spread_mode_target = `SPREAD_POS_PINCH;
      `MODE_WIDE:    spread_mode_target = `SPREAD_POS_WIDE;
      `MODE_SCISSOR: spread_mode_target = common_target;
    endcase
  end

  // Selection of the byte set that drives each axis
  always_comb begin
    // Finger A follows the common set; scissor parking below overrides its target
    sel_target[0] = common_target;
    sel_speed[0]  = common_speed_reg;
    sel_force[0]  = common_force_reg;
    if (fingers_own) begin
      sel_target[1] = second_finger_target_reg;
      sel_speed[1]  = second_finger_speed_reg;
      sel_force[1]  = second_finger_force_reg;
      sel_target[2] = third_finger_target_reg;
      sel_speed[2]  = third_finger_speed_reg;
      sel_force[2]  = third_finger_force_reg;
    end else begin
      sel_target[1] = common_target;
      sel_speed[1]  = common_speed_reg;
      sel_force[1]  = common_force_reg;
      sel_target[2] = common_target;
      sel_speed[2]  = common_speed_reg;
      sel_force[2]  = common_force_reg;
    end
    // Finger flag has no say here
    if (grasping_mode_select == `MODE_SCISSOR
        && !individual_spread_control) begin
      // In scissor mode without individual spread control the fingers park and the spread axis grips
      sel_target[0] = `FINGER_POS_SCISSOR;
      sel_target[1] = `FINGER_POS_SCISSOR;
      sel_target[2] = `FINGER_POS_SCISSOR;
    end
    if (individual_spread_control) begin
      sel_target[3] = spread_axis_target_reg;
      sel_speed[3]  = spread_axis_speed_reg;
      sel_force[3]  = spread_axis_force_reg;
    end else begin
      sel_target[3] = spread_mode_target;
      sel_speed[3]  = common_speed_reg;
      sel_force[3]  = common_force_reg;
    end
  end

  // Free spread axis gets a tighter closed limit so B and C cannot clash
  always_comb begin
    soft_min[0] = `FINGER_SOFT_MIN;
    soft_min[1] = `FINGER_SOFT_MIN;
    soft_min[2] = `FINGER_SOFT_MIN;
    soft_min[3] = `SPREAD_SOFT_MIN;
    soft_max[0] = `FINGER_SOFT_MAX;
    soft_max[1] = `FINGER_SOFT_MAX;
    soft_max[2] = `FINGER_SOFT_MAX;
    soft_max[3] = individual_spread_control ? `SPREAD_SOFT_MAX_ICS
                                            : `SPREAD_SOFT_MAX;
  end

  genvar ax;
  generate
    for (ax = 0; ax < 4; ax = ax + 1) begin : g_axis
      byte_t        clamped;
      byte_t        target_reg;
      word_t        speed_prod;
      word_t        speed_reg;
      byte_t        current_limit;
      word_t        force_val;
      byte_t        position;
      axis_phase_e  phase;
      logic         moving_reg;
      logic         at_target_reg;
      logic         detect_reg;

      // Unsigned target, 00 open stop, FF closed stop
      // Out-of-range request is replaced by the limit
      always_comb begin
        if (sel_target[ax] < soft_min[ax]) begin
          clamped = soft_min[ax];
        end else if (sel_target[ax] > soft_max[ax]) begin
          clamped = soft_max[ax];
        end else begin
          clamped = sel_target[ax];
        end
      end

      assign speed_prod = 16'(sel_speed[ax] * `SPEED_STEP_CMPS);

      always_ff @(posedge sys_clk) begin
        if (rst) begin
          target_reg <= `CMD_RESET_VAL;
          speed_reg  <= `SPEED_MIN_CMPS;
        end else begin
          target_reg <= clamped;
          // Code 0 is the slowest real speed, not a halt
          speed_reg  <= `SPEED_MIN_CMPS + speed_prod;
        end
      end

      force_current_map u_force (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .force_code    (sel_force[ax]),
        .current_limit (current_limit),
        .force_mn      (force_val)
      );

      axis_motion u_motion (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .go_request    (go_request),
        .target        (target_reg),
        .speed_code    (sel_speed[ax]),
        .current_limit (current_limit),
        .motor_current (motor_current[ax]),
        .position      (position),
        .phase         (phase)
      );

      // Reaching a clamped limit counts as reaching the request
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          moving_reg    <= 1'b0;
          at_target_reg <= 1'b0;
          detect_reg    <= 1'b0;
        end else begin
          moving_reg    <= phase == AX_MOVING;
          at_target_reg <= phase == AX_AT_TARGET;
          detect_reg    <= phase == AX_CONTACT;
        end
      end

      assign axis_position[ax]   = position;
      assign axis_target[ax]     = target_reg;
      assign axis_speed_cmps[ax] = speed_reg;
      assign axis_force_mn[ax]   = force_val;
      assign axis_moving[ax]     = moving_reg;
      assign axis_at_target[ax]  = at_target_reg;
      assign object_detect[ax]   = detect_reg;
    end
  endgenerate
endmodule
`default_nettype wire

// ---- test/bus_writer.sv ----
// Purpose: Controller model that writes command bytes one at a time.
// Assumes: Strobe is a one-cycle pulse launched at a falling edge.
// Notes:   Idle bus shows inverted last values so stale bytes stand out.
`timescale 1ns/10ps
`default_nettype none
module bus_writer (
  input  wire logic             sys_clk,   // Clock
  output var  logic             wr_strobe, // Byte write
  output var  logic [3:0]       wr_addr,   // Byte offset
  output var  grip_pkg::byte_t  wr_data    // Byte
);
  import grip_pkg::*;
  initial begin
    wr_strobe = 1'b0;
    wr_addr = 4'h0;
    wr_data = 8'h00;
  end
  task automatic put(input logic [3:0] a, input byte_t d);
    @(negedge sys_clk);
    wr_strobe = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge sys_clk);
    wr_strobe = 1'b0;
    wr_addr = ~a;
    wr_data = ~d;
  endtask
endmodule
`default_nettype wire

// ---- test/grip_cmd_asserts.sv ----
// Purpose: Port checks of the axis command bank.
// Assumes: Bench holds motor current steady during a contact run.
// Notes:   Bound into the design at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
`include "grip_defines.svh"
module grip_cmd_asserts (
  input wire logic                   sys_clk,         // Clock
  input wire logic                   rst,             // Reset
  input wire logic                   wr_strobe,       // Write
  input wire logic [3:0]             wr_addr,         // Offset
  input wire grip_pkg::byte_t        wr_data,         // Data
  input wire logic [3:0]             rd_addr,         // Read offset
  input wire grip_pkg::byte_t        rd_data,         // Read data
  input wire logic                   individual_spread_control, // Flag
  input wire logic [1:0]             grasping_mode_select,      // Mode
  input wire logic                   go_request,      // Go
  input wire grip_pkg::byte_t [3:0]  motor_current,   // Current
  input wire grip_pkg::byte_t [3:0]  axis_position,   // Position
  input wire grip_pkg::byte_t [3:0]  axis_target,     // Target
  input wire grip_pkg::word_t [3:0]  axis_speed_cmps, // Speed
  input wire grip_pkg::word_t [3:0]  axis_force_mn,   // Force
  input wire logic [3:0]             axis_moving,     // Moving
  input wire logic [3:0]             axis_at_target,  // Reached
  input wire logic [3:0]             object_detect    // Contact
);
  import grip_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  rd_unmapped_a: assert property (
    rd_addr < 4'h4 || rd_addr == 4'hF |=> rd_data == `UNMAPPED_READ)
    else $error("unmapped read not zero");
  wr_read_a: assert property (
    wr_strobe && rd_addr == wr_addr && wr_addr > 4'h3 && wr_addr < 4'hF
    ##1 !wr_strobe && $stable(rd_addr) |=> rd_data == $past(wr_data, 2))
    else $error("written byte not read back");
  speed_map_a: assert property (
    (axis_speed_cmps[0] - `SPEED_MIN_CMPS) % `SPEED_STEP_CMPS == 16'h0000
    && axis_speed_cmps[0] >= 16'h0898 && axis_speed_cmps[0] <= 16'h2A76)
    else $error("speed off the scale");
  force_map_a: assert property (
    (axis_force_mn[1] - `FORCE_MIN_MN) % `FORCE_STEP_MN == 16'h0000
    && axis_force_mn[1] >= 16'h3A98 && axis_force_mn[1] <= 16'hE8E9)
    else $error("force off the scale");
  finger_clamp_a: assert property (
    !$past(rst) && $past(grasping_mode_select) != `MODE_SCISSOR
    |-> axis_target[1] >= `FINGER_SOFT_MIN
    && axis_target[1] <= `FINGER_SOFT_MAX)
    else $error("finger target outside soft limits");
  spread_ics_a: assert property (
    !$past(rst) && $past(individual_spread_control)
    |-> axis_target[3] <= `SPREAD_SOFT_MAX_ICS)
    else $error("spread target above reduced limit");
  mode_basic_a: assert property (
    !$past(rst) && !$past(individual_spread_control)
    && $past(grasping_mode_select) == `MODE_BASIC
    |-> axis_target[3] == `SPREAD_POS_BASIC)
    else $error("basic mode spread target wrong");
  contact_a: assert property (
    $rose(object_detect[0])
    |-> !axis_moving[0] && motor_current[0] > `CURRENT_BASE)
    else $error("contact flag without over-current stop");
  go_low_a: assert property (
    !go_request [*3] |-> axis_moving == 4'h0 && object_detect == 4'h0)
    else $error("axes not idle after go dropped");
  at_pos_a: assert property (
    $stable(axis_target[0]) [*3] ##0 axis_at_target[0]
    |-> axis_position[0] == axis_target[0])
    else $error("reached flag away from target");
  contact_c: cover property ($rose(object_detect[0]));
  reached_c: cover property ($rose(axis_at_target[0]));
  ics_wr_c: cover property (wr_strobe && individual_spread_control);
endmodule
bind gripper_axis_command_regs grip_cmd_asserts chk_u (
  .sys_clk(sys_clk), .rst(rst), .wr_strobe(wr_strobe),
  .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
  .rd_data(rd_data),
  .individual_spread_control(individual_spread_control),
  .grasping_mode_select(grasping_mode_select),
  .go_request(go_request), .motor_current(motor_current),
  .axis_position(axis_position), .axis_target(axis_target),
  .axis_speed_cmps(axis_speed_cmps), .axis_force_mn(axis_force_mn),
  .axis_moving(axis_moving), .axis_at_target(axis_at_target),
  .object_detect(object_detect));
`default_nettype wire

// ---- test/gripper_axis_command_regs_tb.sv ----
// Purpose: Self-checking bench of the axis command bank.
// Assumes: Inputs change at falling edges; 250 MHz clock.
// Notes:   Motions kept short so the run stays brief.
`timescale 1ns/10ps
`default_nettype none
`include "grip_defines.svh"
module gripper_axis_command_regs_tb;
  import grip_pkg::*;
  logic sys_clk, rst, wr_strobe, go_request;
  logic individual_finger_control, individual_spread_control;
  logic [3:0] wr_addr, rd_addr, axis_moving, axis_at_target, object_detect;
  logic [1:0] grasping_mode_select;
  byte_t wr_data, rd_data, common_target;
  byte_t [3:0] motor_current, axis_position, axis_target;
  word_t [3:0] axis_speed_cmps, axis_force_mn;
  int miscompares = 0;
  int num_checks = 0;
  bus_writer ctl_u (.sys_clk(sys_clk), .wr_strobe(wr_strobe),
    .wr_addr(wr_addr), .wr_data(wr_data));
  gripper_axis_command_regs dut_u (.sys_clk(sys_clk), .rst(rst),
    .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data), .common_target(common_target),
    .individual_finger_control(individual_finger_control),
    .individual_spread_control(individual_spread_control),
    .grasping_mode_select(grasping_mode_select), .go_request(go_request),
    .motor_current(motor_current), .axis_position(axis_position),
    .axis_target(axis_target), .axis_speed_cmps(axis_speed_cmps),
    .axis_force_mn(axis_force_mn), .axis_moving(axis_moving),
    .axis_at_target(axis_at_target), .object_detect(object_detect));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  function automatic word_t spd(input byte_t c);
    return `SPEED_MIN_CMPS + `SPEED_STEP_CMPS * c;
  endfunction
  function automatic word_t frc(input byte_t c);
    return `FORCE_MIN_MN + `FORCE_STEP_MN * c;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, output byte_t v);
    @(negedge sys_clk);
    rd_addr = a;
    @(negedge sys_clk);
    v = rd_data;
  endtask
  task automatic set_opts(input logic f, s, input logic [1:0] m);
    @(negedge sys_clk);
    individual_finger_control = f;
    individual_spread_control = s;
    grasping_mode_select = m;
    cyc(3);
  endtask
  // Bounded wait on axis A: reached flag, or contact flag
  task automatic wait_a(input logic contact);
    int n;
    n = 0;
    while ((contact ? object_detect[0] : axis_at_target[0]) !== 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (n > 8000) begin
        miscompares++;
        wrap_up();
      end
    end
  endtask
  task automatic do_reset();
    rst = 1'b1;
    cyc(16);
    rst = 1'b0;
    cyc(2);
  endtask
  task automatic t_regs();
    byte_t v;
    for (int i = 0; i < 16; i++) begin
      rd(i[3:0], v);
      check({8'h00, v}, 16'h0000);
    end
    for (int i = 4; i < 15; i++) begin
      rd_addr = i[3:0];
      ctl_u.put(i[3:0], {i[3:0], ~i[3:0]});
      // Offset held one more cycle so the read-back checker sees it
      cyc(1);
    end
    set_opts(1'b1, 1'b1, `MODE_PINCH);
    for (int i = 0; i < 16; i++) begin
      rd(i[3:0], v);
      check(v, (i > 3 && i < 15) ? {i[3:0], ~i[3:0]} : 8'h00);
    end
    $display("t_regs done");
  endtask
  task automatic t_select();
    ctl_u.put(`OFS_COMMON_SPEED, 8'hFF);
    ctl_u.put(`OFS_COMMON_FORCE, 8'h00);
    ctl_u.put(`OFS_SECOND_SPEED, 8'h00);
    ctl_u.put(`OFS_SECOND_FORCE, 8'hFF);
    ctl_u.put(`OFS_THIRD_SPEED, 8'h10);
    ctl_u.put(`OFS_THIRD_FORCE, 8'h20);
    ctl_u.put(`OFS_SPREAD_SPEED, 8'h80);
    ctl_u.put(`OFS_SPREAD_FORCE, 8'h40);
    for (int f = 0; f < 2; f++) begin
      set_opts(f[0], f[0], `MODE_BASIC);
      check(axis_speed_cmps[0], spd(8'hFF));
      check(axis_force_mn[0], frc(8'h00));
      check(axis_speed_cmps[1], spd(f ? 8'h00 : 8'hFF));
      check(axis_force_mn[1], frc(f ? 8'hFF : 8'h00));
      check(axis_speed_cmps[2], spd(f ? 8'h10 : 8'hFF));
      check(axis_force_mn[2], frc(f ? 8'h20 : 8'h00));
    end
    check(axis_speed_cmps[3], spd(8'h80));
    check(axis_force_mn[3], frc(8'h40));
    $display("t_select done");
  endtask
  task automatic t_target();
    byte_t tbl [3];
    tbl = '{`SPREAD_POS_BASIC, `SPREAD_POS_PINCH, `SPREAD_POS_WIDE};
    common_target = 8'h80;
    ctl_u.put(`OFS_SECOND_TARGET, 8'hFF);
    ctl_u.put(`OFS_THIRD_TARGET, 8'h00);
    ctl_u.put(`OFS_SPREAD_TARGET, 8'hFF);
    set_opts(1'b1, 1'b1, `MODE_SCISSOR);
    check(axis_target[0], 16'h0080);
    check(axis_target[1], `FINGER_SOFT_MAX);
    check(axis_target[2], `FINGER_SOFT_MIN);
    check(axis_target[3], `SPREAD_SOFT_MAX_ICS);
    set_opts(1'b1, 1'b0, `MODE_SCISSOR);
    // Parked finger lands on its open soft limit
    check(axis_target[1], `FINGER_SOFT_MIN);
    check(axis_speed_cmps[1], spd(8'hFF));
    check(axis_target[3], 16'h0080);
    for (int m = 0; m < 3; m++) begin
      set_opts(1'b1, 1'b0, m[1:0]);
      check(axis_target[3], tbl[m]);
    end
    $display("t_target done");
  endtask
  task automatic t_motion();
    do_reset();
    set_opts(1'b0, 1'b0, `MODE_BASIC);
    ctl_u.put(`OFS_COMMON_SPEED, 8'hFF);
    common_target = 8'h10;
    go_request = 1'b1;
    cyc(4);
    wait_a(1'b0);
    check(axis_position[0], 16'h0010);
    ctl_u.put(`OFS_COMMON_SPEED, 8'hF0);
    cyc(20);
    check(axis_moving[2:0], 16'h0000);
    check(axis_speed_cmps[0], spd(8'hF0));
    common_target = 8'h00;
    cyc(4);
    wait_a(1'b0);
    check(axis_position[0], `FINGER_SOFT_MIN);
    $display("t_motion done");
  endtask
  task automatic t_contact();
    go_request = 1'b0;
    motor_current[0] = 8'hFF;
    ctl_u.put(`OFS_COMMON_FORCE, 8'h00);
    common_target = 8'h40;
    cyc(3);
    go_request = 1'b1;
    cyc(4);
    wait_a(1'b1);
    check(axis_moving[0], 16'h0000);
    check({15'h0000, axis_position[0] >= 8'h0E}, 16'h0001);
    check({15'h0000, axis_position[0] < 8'h40}, 16'h0001);
    go_request = 1'b0;
    cyc(4);
    check(object_detect, 16'h0000);
    $display("t_contact done");
  endtask
  initial begin
    rst = 1'b1;
    rd_addr = 4'h0;
    common_target = 8'h00;
    individual_finger_control = 1'b0;
    individual_spread_control = 1'b0;
    grasping_mode_select = 2'h0;
    go_request = 1'b0;
    motor_current = '0;
    do_reset();
    t_regs();
    t_select();
    t_target();
    t_motion();
    t_contact();
    wrap_up();
  end
endmodule
`default_nettype wire
